// ===== sync_periph_cycle.sv
// Synchronous peripheral bus cycle engine with autovector support.
// Assumes pins are synchronised here; states step on every clk_sys edge pair.
`timescale 1ns/10ps
module sync_periph_cycle
	import sync_bus_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// Request side
	input  wire logic                      reqValid,
	input  wire sync_bus_pkg::bus_req_type req,
	output logic                           reqBusy,
	output logic                           doneValid,
	output logic [sync_bus_pkg::DATA_W-1:0] doneData,
	// Peripheral pins
	input  wire logic [sync_bus_pkg::DATA_W-1:0] dataIn,
	input  wire logic                      syncPeriphSelectN,
	output sync_bus_pkg::bus_pins_type     pins,
	output logic                           enableOut
);
	import sync_bus_pkg::*;

	// ****************************************
	// Pin synchroniser and enable clock
	// ****************************************
	logic              selMeta_q;
	logic              selSync_q;
	logic [DATA_W-1:0] dataMeta_q;
	logic [DATA_W-1:0] dataSync_q;
	logic              enableClk;
	logic              enableLowLast;

	// The data bus is held through the enable high phase, so its two-stage copy
	// has settled well before state six takes it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			selMeta_q  <= 1'b0;
			selSync_q  <= 1'b0;
			dataMeta_q <= '0;
			dataSync_q <= '0;
		end else begin
			selMeta_q  <= !syncPeriphSelectN;
			selSync_q  <= selMeta_q;
			dataMeta_q <= dataIn;
			dataSync_q <= dataMeta_q;
		end
	end

	enable_clock_gen u_enable (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.enableClk    (enableClk),
		.enableLowLast(enableLowLast)
	);

	function automatic logic [7:0] autoVector(input logic [2:0] level);
		autoVector = AUTOVEC_BASE + {5'h00, level};
	endfunction : autoVector

	// ****************************************
	// Cycle state machine
	// ****************************************
	// Each of states S0-S4, S6 and S7 lasts one clk_sys cycle here, modelling a half-clock step
	bus_state_type state_q;
	bus_state_type state_d;
	bus_req_type   req_q;
	bus_req_type   req_d;
	bus_pins_type  pins_q;
	bus_pins_type  pins_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic          done_q;
	logic          done_d;
	logic          busy_q;
	logic          busy_d;
	logic [1:0]    xferCnt_q;
	logic [1:0]    xferCnt_d;

	always_comb begin
		state_d = state_q;
		req_d   = req_q;
		pins_d  = pins_q;
		rdata_d = rdata_q;
		done_d  = 1'b0;
		xferCnt_d = xferCnt_q;
		case (state_q)
			ST_IDLE: begin
				if (reqValid) begin
					req_d            = req;
					pins_d.funcCode  = req.funcCode;
					pins_d.addrOeN   = 1'b1;
					state_d          = ST_S0;
				end
			end
			ST_S0: begin
				pins_d.addrOut = req_q.addr;
				pins_d.addrOeN = 1'b0;
				state_d        = ST_S1;
			end
			ST_S1: begin
				pins_d.addrValidN = 1'b0;
				if (!req_q.write) begin
					pins_d.dataStrobeN = 1'b0;
				end else begin
					pins_d.rdWr = 1'b0;
				end
				state_d = ST_S2;
			end
			ST_S2: begin
				if (req_q.write) begin
					pins_d.dataOut = req_q.wdata;
					pins_d.dataOeN = 1'b0;
				end
				state_d = ST_S3;
			end
			ST_S3: begin
				if (req_q.write) begin
					pins_d.dataStrobeN = 1'b0;
				end
				state_d = ST_S4;
			end
			ST_S4: begin
				state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (selSync_q) begin
					state_d = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				if (enableLowLast) begin
					state_d   = ST_XFER;
					xferCnt_d = 2'h0;
				end
			end
			ST_XFER: begin
				// Transfer sits in the enable high phase; state six takes its last clock
				if (xferCnt_q == 2'(ENABLE_PERIOD - ENABLE_LOW - 2)) begin
					state_d = ST_S6;
				end else begin
					xferCnt_d = xferCnt_q + 2'h1;
				end
			end
			ST_S6: begin
				if (!req_q.write) begin
					rdata_d = req_q.iack ? autoVector(req_q.level) : dataSync_q;
				end
				pins_d.addrValidN  = 1'b1;
				pins_d.dataStrobeN = 1'b1;
				state_d            = ST_S7;
			end
			ST_S7: begin
				pins_d.addrOeN = 1'b1;
				pins_d.dataOeN = 1'b1;
				pins_d.rdWr    = 1'b1;
				state_d        = ST_END;
			end
			ST_END: begin
				done_d  = 1'b1;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			req_q   <= '0;
			pins_q  <= '{addrOut: '0, addrOeN: 1'b1, dataOut: '0, dataOeN: 1'b1, funcCode: 3'h0,
			             addrValidN: 1'b1, dataStrobeN: 1'b1, rdWr: 1'b1};
			rdata_q <= '0;
			done_q  <= 1'b0;
			busy_q  <= 1'b0;
			xferCnt_q <= 2'h0;
		end else begin
			state_q <= state_d;
			req_q   <= req_d;
			pins_q  <= pins_d;
			rdata_q <= rdata_d;
			done_q  <= done_d;
			busy_q  <= busy_d;
			xferCnt_q <= xferCnt_d;
		end
	end

	assign pins      = pins_q;
	assign doneData  = rdata_q;
	assign doneValid = done_q;
	assign reqBusy   = busy_q;
	// Straight from the divider flop, so it falls together with the strobes in state seven
	assign enableOut = enableClk;

	// ****************************************
	// Checks
	// ****************************************
	a_strobe_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_S2 && !req_q.write) |-> (!pins_q.addrValidN && !pins_q.dataStrobeN))
		else $error("read strobes late");
	a_write_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_S2 && req_q.write) |-> !pins_q.rdWr && pins_q.dataStrobeN ##1 !pins_q.dataOeN ##1
		!pins_q.dataStrobeN) else $error("write sequence wrong");
	a_addr_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_S0) |-> pins_q.addrOeN ##1 !pins_q.addrOeN) else $error("address enable wrong");
	a_wait_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WAIT && !selSync_q) |=> state_q == ST_WAIT) else $error("left wait early");
	a_xfer_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_XFER) |-> enableOut || $rose(enableClk)) else $error("transfer outside high");
	a_strobe_neg: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_S7) |-> pins_q.addrValidN && pins_q.dataStrobeN && !enableClk)
		else $error("strobes not negated");
	a_end_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_END) |-> pins_q.addrOeN && pins_q.dataOeN && pins_q.rdWr)
		else $error("bus not released");
	a_autovec_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(doneValid && req_q.iack) |-> (doneData >= 8'h19 && doneData <= 8'h1f))
		else $error("autovector out of range");
	a_cycle_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_ALIGN) |-> ##[1:20] state_q == ST_S6) else $error("align too long");

	c_read: cover property (@(posedge clk_sys) state_q == ST_S6 && !req_q.write);
	c_write: cover property (@(posedge clk_sys) state_q == ST_S6 && req_q.write);
	c_iack: cover property (@(posedge clk_sys) doneValid && req_q.iack);
endmodule : sync_periph_cycle

// ===== sync_bus_pkg.sv
// Package for the synchronous peripheral bus cycle engine.
// Assumes a single system clock; all timing is counted in its cycles.
package sync_bus_pkg;

	// ****************************************
	// Enable clock divider
	// ****************************************
	localparam int unsigned ENABLE_PERIOD = 10;
	localparam int unsigned ENABLE_LOW    = 6;
	localparam logic [3:0] ENABLE_CNT_RESET = 4'h0;

	// ****************************************
	// Widths and vectors
	// ****************************************
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] AUTOVEC_BASE = 8'h18; // 24 + level gives 25..31 for levels 1..7, 24 for level 0
	localparam logic [2:0] FC_IACK = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_S0    = 4'b0001,
		ST_S1    = 4'b0010,
		ST_S2    = 4'b0011,
		ST_S3    = 4'b0100,
		ST_S4    = 4'b0101,
		ST_WAIT  = 4'b0110,
		ST_ALIGN = 4'b0111,
		ST_XFER  = 4'b1000,
		ST_S6    = 4'b1001,
		ST_S7    = 4'b1010,
		ST_END   = 4'b1011
	} bus_state_type;

	typedef struct packed {
		logic              write;
		logic              iack;
		logic [2:0]        level;
		logic [2:0]        funcCode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addrOut;
		logic              addrOeN;
		logic [DATA_W-1:0] dataOut;
		logic              dataOeN;
		logic [2:0]        funcCode;
		logic              addrValidN;
		logic              dataStrobeN;
		logic              rdWr;
	} bus_pins_type;

endpackage : sync_bus_pkg

// ===== enable_clock_gen.sv
// Free-running enable clock: 6 clocks low, 4 high, and phase pulses.
// Assumes clk_sys is the processor input clock.
`timescale 1ns/10ps
module enable_clock_gen
	import sync_bus_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Enable clock
	output logic      enableClk,
	output logic      enableLowLast
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic       en_q;
	logic       en_d;

	always_comb begin
		cnt_d = (cnt_q == 4'(ENABLE_PERIOD - 1)) ? 4'h0 : cnt_q + 4'h1;
		en_d  = (cnt_d >= 4'(ENABLE_LOW));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= ENABLE_CNT_RESET;
			en_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			en_q  <= en_d;
		end
	end

	assign enableClk     = en_q;
	// High next cycle: last low clock
	assign enableLowLast = (cnt_q == 4'(ENABLE_LOW - 1));

	a_enable_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(en_q) |-> en_q[*4] ##1 !en_q[*6]) else $error("enable duty wrong");
endmodule : enable_clock_gen

// ===== sync_periph_model.sv
// Peripheral-side model: address decode for the select and a read data source.
// Assumes the device pins struct of sync_bus_pkg and one clk_sys domain.
`timescale 1ns/10ps
module sync_periph_model
	import sync_bus_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	// Device side
	input  wire sync_bus_pkg::bus_pins_type pins,
	input  wire logic                       enableOut,
	input  wire logic [7:0]                 selDelay,
	// Answers
	output logic                            syncPeriphSelectN,
	output logic [sync_bus_pkg::DATA_W-1:0] dataIn,
	output logic [sync_bus_pkg::DATA_W-1:0] periphWrData
);
	int unsigned waitCnt;
	logic        validMemQualN;
	logic        periphHit;
	logic        chipSel;

	// Decode leaves out the acknowledge cycle, so autovectoring touches no peripheral
	assign periphHit = (pins.addrOut[19:16] == 4'hf) && (pins.funcCode != FC_IACK);
	// Chip select is qualified by the active-low memory qualifier, not the address strobe
	assign chipSel   = periphHit && !validMemQualN;

	// ****************************************
	// Select decode and data
	// ****************************************
	// No acknowledge line exists here, so none can collide with the select
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt <= 0;
			syncPeriphSelectN <= 1'b1;
			validMemQualN <= 1'b1;
			dataIn <= 8'h00;
			periphWrData <= 8'h00;
		end else begin
			// Undriven bus keeps changing so stale data never matches
			dataIn <= ~dataIn;
			if (pins.addrValidN) begin
				waitCnt <= 0;
				syncPeriphSelectN <= 1'b1;
				validMemQualN <= 1'b1;
			end else begin
				waitCnt <= waitCnt + 1;
				if (waitCnt >= selDelay && pins.addrOut[19:16] == 4'hf) begin
					syncPeriphSelectN <= 1'b0;
				end
				// Qualifier goes low only while the enable clock is low
				if (!syncPeriphSelectN && !enableOut) begin
					validMemQualN <= 1'b0;
				end
				if (chipSel && !pins.dataStrobeN && pins.rdWr) begin
					dataIn <= pins.addrOut[7:0] ^ 8'h5a;
				end
				// Peripheral latches write data in the enable high phase
				if (chipSel && !pins.dataStrobeN && !pins.rdWr && enableOut) begin
					periphWrData <= pins.dataOut;
				end
			end
		end
	end
endmodule : sync_periph_model

// ===== sync_peripheral_bus_cycle_tb.sv
// Self-checking bench for the synchronous peripheral cycle engine.
// Assumes sync_periph_cycle, sync_periph_model and sync_bus_pkg are compiled.
`timescale 1ns/10ps
module sync_peripheral_bus_cycle_tb;
	import sync_bus_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n;
	logic         reqValid;
	bus_req_type  req;
	logic         reqBusy;
	logic         doneValid;
	logic [7:0]   doneData;
	logic [7:0]   dataIn;
	logic         syncPeriphSelectN;
	bus_pins_type pins;
	logic         enableOut;
	logic [7:0]   selDelay;
	int           num_errors = 0;
	int           compares = 0;
	int           t[6];
	logic [2:0]   fcPre;
	logic [2:0]   oeZ;
	logic [1:0]   enE;
	logic [7:0]   got;
	logic [7:0]   wSeen;
	logic         aOe0;
	logic [7:0]   periphWrData;

	sync_periph_cycle dut (.clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .req(req), .reqBusy(reqBusy),
		.doneValid(doneValid), .doneData(doneData), .dataIn(dataIn), .syncPeriphSelectN(syncPeriphSelectN),
		.pins(pins), .enableOut(enableOut));
	sync_periph_model periph (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .enableOut(enableOut),
		.selDelay(selDelay), .syncPeriphSelectN(syncPeriphSelectN), .dataIn(dataIn),
		.periphWrData(periphWrData));

	always #12.5 clk_sys = ~clk_sys;

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Runs one cycle; t holds first cycles of: addr drive, strobe, data strobe, data drive, dir low, strobe end
	task run_cycle(input logic wr, input logic ia, input logic [2:0] lvl, input logic [19:0] a,
		input logic [7:0] wd, input logic [7:0] dly);
		int   n;
		logic prevEn;
		t = '{default: 0};
		n = 0;
		prevEn = 1'b0;
		@(posedge clk_sys);
		selDelay <= dly;
		req <= '{write: wr, iack: ia, level: lvl, funcCode: (ia ? FC_IACK : 3'h5), addr: a, wdata: wd};
		reqValid <= 1'b1;
		@(posedge clk_sys);
		reqValid <= 1'b0;
		#1;
		fcPre = pins.funcCode;
		aOe0 = pins.addrOeN;
		chk("busy in state zero", 1'b1, reqBusy);
		do begin
			@(posedge clk_sys);
			#1;
			n++;
			if (pins.addrOeN === 1'b0 && t[0] == 0) t[0] = n;
			if (pins.addrValidN === 1'b0 && t[1] == 0) t[1] = n;
			if (pins.dataStrobeN === 1'b0 && t[2] == 0) t[2] = n;
			if (pins.dataOeN === 1'b0 && t[3] == 0) wSeen = pins.dataOut;
			if (pins.dataOeN === 1'b0 && t[3] == 0) t[3] = n;
			if (pins.rdWr === 1'b0 && t[4] == 0) t[4] = n;
			if (t[5] != 0 && n == t[5] + 1) oeZ = {pins.addrOeN, pins.dataOeN, pins.rdWr};
			if (t[1] != 0 && pins.addrValidN === 1'b1 && t[5] == 0) begin
				t[5] = n;
				enE = {prevEn, enableOut};
			end
			prevEn = enableOut;
		end while (doneValid !== 1'b1 && n < 300);
		got = doneData;
		chk("cycle ended", 1'b1, doneValid);
		chk("idle after cycle", 1'b0, reqBusy);
	endtask : run_cycle

	// ****************************************
	// Scenarios
	// ****************************************
	task test_enable;
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		do begin
			@(posedge clk_sys);
			#1;
		end while (enableOut !== 1'b0);
		do begin
			@(posedge clk_sys);
			#1;
		end while (enableOut !== 1'b1);
		while (enableOut === 1'b1) begin
			hi++;
			@(posedge clk_sys);
			#1;
		end
		while (enableOut === 1'b0) begin
			lo++;
			@(posedge clk_sys);
			#1;
		end
		chk("enable high", 4, hi);
		chk("enable low", 6, lo);
		chk("enable period", 10, hi + lo);
		$display("test_enable done");
	endtask : test_enable

	task test_read;
		run_cycle(1'b0, 1'b0, 3'h0, 20'hf0012, 8'h00, 8'h03);
		chk("function code at state zero", 3'h5, fcPre);
		chk("address floated at state zero", 1'b1, aOe0);
		chk("address strobe after drive", t[0] + 1, t[1]);
		chk("read data strobe", t[1], t[2]);
		chk("read direction", 0, t[4]);
		chk("enable fall at strobe end", 2'b10, enE);
		chk("address floated", 1'b1, oeZ[2]);
		chk("read data", 8'h12 ^ 8'h5a, got);
		$display("test_read done");
	endtask : test_read

	task test_write;
		run_cycle(1'b1, 1'b0, 3'h0, 20'hf0034, 8'ha5, 8'h03);
		chk("direction low", t[1], t[4]);
		chk("write data drive", t[1] + 1, t[3]);
		chk("write data", 8'ha5, wSeen);
		chk("peripheral write data", 8'ha5, periphWrData);
		chk("write data strobe", t[1] + 2, t[2]);
		chk("enable fall at strobe end", 2'b10, enE);
		chk("bus floated", 3'b111, oeZ);
		$display("test_write done");
	endtask : test_write

	task test_slow;
		run_cycle(1'b0, 1'b0, 3'h0, 20'hf0056, 8'h00, 8'h28);
		chk("waits for select", 1, t[5] > t[1] + 40);
		chk("slow read data", 8'h56 ^ 8'h5a, got);
		$display("test_slow done");
	endtask : test_slow

	task test_autovec;
		for (int lvl = 1; lvl < 8; lvl++) begin
			run_cycle(1'b0, 1'b1, lvl[2:0], 20'hffff0, 8'h00, 8'h03);
			chk("acknowledge function code", 3'h7, fcPre);
			chk("autovector", 8'h18 + lvl[7:0], got);
		end
		$display("test_autovec done");
	endtask : test_autovec

	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		selDelay = 8'h03;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		test_enable;
		test_read;
		test_write;
		test_slow;
		test_autovec;
		tally_and_finish;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish;
	end
endmodule : sync_peripheral_bus_cycle_tb
